// ---- src/irq_vector_sequencer.sv ----
// Reset and interrupt vector sequencer with Wishbone register slave
//
// Contract
// - serve source only with own and global enable
// - lower vector address wins among pending
// - reset first, external_request_zero next
// - accepting interrupt clears global enable
// - software may re-enable globally inside handler
// - return_from_irq_instr sets global enable
// - hardware clears flag when vectoring
// - writing one clears flag, zero keeps
// - flag holds while source disabled
// - flags held while globally masked, served by priority
// - level sources request only while condition present
// - one main instruction runs after return
// - processor_status_reg never saved nor restored
// - global disable masks at once, same cycle
// - instruction after global enable runs first
// - entry takes four cycles, pushes program_counter
// - vector jump adds three cycles
// - multi-cycle instruction completes before entry
// - wake from sleep adds four cycles
// - return takes four cycles, pops two bytes
// - entry push lowers stack pointer by two
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "irq_vector_sequencer_consts.svh"

module irq_vector_sequencer #(
    parameter int NSRC = 8,
    parameter logic [NSRC-1:0] FLAG_TYPE = 8'hFF,
    parameter logic [15:0] SP_RESET = 16'h00FF
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Wishbone classic slave
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [7:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK,
    // Peripheral sources, same clock
    input wire logic [NSRC-1:0] IRQ_EVENT,
    input wire logic [NSRC-1:0] IRQ_LEVEL,
    // Instruction sequencer status
    input wire logic INSTR_DONE,
    input wire logic INSTR_SEI,
    input wire logic INSTR_CLI,
    input wire logic INSTR_RETURN_FROM_IRQ_INSTR,
    input wire logic SLEEPING,
    input wire logic [15:0] PC_RETURN,
    input wire logic [15:0] JUMP_TARGET,
    // Control toward the core
    output logic CORE_HOLD,
    output logic GLOBAL_EN,
    output irq_vector_sequencer_pkg::pc_load_t PC_LOAD,
    // Stack memory port
    output irq_vector_sequencer_pkg::stk_req_t STK_REQ,
    input wire logic [7:0] STK_RDATA
);

    // Register state
    logic gie;                   // Global enable
    logic [NSRC-1:0] enable;     // Per source enable
    logic [NSRC-1:0] flags;      // Latched event flags
    logic [15:0] sp;             // Stack pointer

    // Sequencer state
    irq_vector_sequencer_pkg::seq_state_t state;
    logic [3:0] step;            // Cycle within a sequence
    logic [3:0] entry_len;       // Entry length, grows on wake
    logic [15:0] ret_pc;         // Return address to push
    logic [15:0] vec;            // Vector of the accepted source
    logic [7:0] pop_hi;          // First popped byte

    // Bus signals
    logic wb_req;
    logic wr_en;
    logic [2:0] hit;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic [31:0] next_rdata;

    // Arbitration signals
    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] hw_clr;
    logic [NSRC-1:0] sw_clr;
    logic [$clog2(NSRC)-1:0] win;
    logic take;
    logic return_from_irq_instr_go;
    logic entry_last;
    logic ret_last;

    // Register index decode, used by read and write paths
    function automatic logic [2:0] decode(input logic [7:0] adr);
        if (adr == `REG_CTRL) begin
            decode = 3'h1;
        end else if (adr == `REG_ENABLE) begin
            decode = 3'h2;
        end else if (adr == `REG_FLAGS) begin
            decode = 3'h3;
        end else if (adr == `REG_SP) begin
            decode = 3'h4;
        end else if (adr == `REG_STATUS) begin
            decode = 3'h5;
        end else begin
            decode = 3'h0;
        end
    endfunction

    // Expand byte selects into a bit mask
    function automatic logic [31:0] lanes(input logic [3:0] sel);
        lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Bus request decode; a write lands once, in the ack cycle
    assign wb_req = WB_CYC && WB_STB;
    assign wr_en = wb_req && WB_WE && WB_ACK;
    assign hit = decode(WB_ADR);
    assign wmask = lanes(WB_SEL);
    assign wdat = WB_DAT_I & wmask;

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            WB_ACK <= 1'b0;
        end else begin
            WB_ACK <= wb_req && !WB_ACK;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit == 3'h1) begin
            next_rdata[`CTRL_GIE_BIT] = gie;
        end else if (hit == 3'h2) begin
            next_rdata[NSRC-1:0] = enable;
        end else if (hit == 3'h3) begin
            next_rdata[NSRC-1:0] = flags;
        end else if (hit == 3'h4) begin
            next_rdata[15:0] = sp;
        end else if (hit == 3'h5) begin
            next_rdata[`STATUS_BUSY_BIT] = (state != irq_vector_sequencer_pkg::ST_IDLE);
            next_rdata[`STATUS_VEC_LSB +: 16] = vec;
        end
    end

    // Read data registered alongside the ack
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (wb_req && !WB_ACK && !WB_WE) begin
            WB_DAT_O <= next_rdata;
        end else begin
            WB_DAT_O <= 32'h0000_0000;
        end
    end

    // Source requests: flags for latched sources, live level otherwise
    always_comb begin
        pending = ((flags & FLAG_TYPE) | (IRQ_LEVEL & ~FLAG_TYPE)) & enable;
    end

    // Lowest index wins; reset owns vector zero outside this block
    always_comb begin
        win = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                win = i[$clog2(NSRC)-1:0];
            end
        end
    end

    // Accept at a boundary only; the old enable value delays by one
    // instruction after a global enable, the wait for the next boundary after a return
    assign take = (state == irq_vector_sequencer_pkg::ST_IDLE) && INSTR_DONE && gie && !INSTR_CLI
        && !INSTR_RETURN_FROM_IRQ_INSTR && (|pending);
    assign return_from_irq_instr_go = (state == irq_vector_sequencer_pkg::ST_IDLE) && INSTR_DONE && INSTR_RETURN_FROM_IRQ_INSTR;
    assign entry_last = (state == irq_vector_sequencer_pkg::ST_ENTRY) && (step == entry_len - 4'h1);
    assign ret_last = (state == irq_vector_sequencer_pkg::ST_RETURN) && (step == `RETURN_CYCLES - 4'h1);

    // Clear strobes for the flag register
    always_comb begin
        hw_clr = '0;
        if (take) begin
            hw_clr[win] = 1'b1;
        end
        sw_clr = (wr_en && hit == 3'h3) ? wdat[NSRC-1:0] : '0;
    end

    // Flags: a new event beats any clear in the same cycle
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            flags <= '0;
        end else begin
            flags <= ((flags & ~hw_clr & ~sw_clr) | IRQ_EVENT) & FLAG_TYPE;
        end
    end

    // Per source enables, software owned
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            enable <= `ENABLE_RESET;
        end else if (wr_en && hit == 3'h2) begin
            enable <= wdat[NSRC-1:0];
        end
    end

    // Global enable: entry clears, return raises, disable instruction clears,
    // set instruction raises, software writes follow
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            gie <= `CTRL_RESET;
        end else if (take) begin
            gie <= 1'b0;
        end else if (ret_last) begin
            gie <= 1'b1;
        end else if (INSTR_CLI && INSTR_DONE) begin
            gie <= 1'b0;
        end else if (INSTR_SEI && INSTR_DONE) begin
            gie <= 1'b1;
        end else if (wr_en && hit == 3'h1 && WB_SEL[0]) begin
            gie <= WB_DAT_I[`CTRL_GIE_BIT];
        end
    end

    // Sequencer state and step counter
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state <= irq_vector_sequencer_pkg::ST_IDLE;
            step <= 4'h0;
        end else begin
            case (state)
                irq_vector_sequencer_pkg::ST_IDLE: begin
                    step <= 4'h0;
                    if (take) begin
                        state <= irq_vector_sequencer_pkg::ST_ENTRY;
                    end else if (return_from_irq_instr_go) begin
                        state <= irq_vector_sequencer_pkg::ST_RETURN;
                    end
                end
                irq_vector_sequencer_pkg::ST_ENTRY: begin
                    if (entry_last) begin
                        state <= irq_vector_sequencer_pkg::ST_JUMP;
                        step <= 4'h0;
                    end else begin
                        step <= step + 4'h1;
                    end
                end
                irq_vector_sequencer_pkg::ST_JUMP: begin
                    if (step == `JUMP_CYCLES - 4'h1) begin
                        state <= irq_vector_sequencer_pkg::ST_IDLE;
                        step <= 4'h0;
                    end else begin
                        step <= step + 4'h1;
                    end
                end
                irq_vector_sequencer_pkg::ST_RETURN: begin
                    if (ret_last) begin
                        state <= irq_vector_sequencer_pkg::ST_IDLE;
                        step <= 4'h0;
                    end else begin
                        step <= step + 4'h1;
                    end
                end
                default: begin
                    state <= irq_vector_sequencer_pkg::ST_IDLE;
                    step <= 4'h0;
                end
            endcase
        end
    end

    // Capture the return address, the vector and the entry length
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ret_pc <= 16'h0000;
            vec <= 16'h0000;
            entry_len <= `ENTRY_CYCLES;
        end else if (take) begin
            ret_pc <= PC_RETURN;
            vec <= 16'(win) + 16'h0001;
            entry_len <= SLEEPING ? (`ENTRY_CYCLES + `SLEEP_EXTRA_CYCLES) : `ENTRY_CYCLES;
        end
    end

    // Stack pointer: pushes and pops outrank a software write
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sp <= SP_RESET;
        end else if (entry_last) begin
            sp <= sp - `SP_STEP;
        end else if (ret_last) begin
            sp <= sp + `SP_STEP;
        end else if (wr_en && hit == 3'h4) begin
            sp <= (sp & ~wmask[15:0]) | wdat[15:0];
        end
    end

    // Stack traffic: low byte pushed first at the top, high below it;
    // the return pops in the opposite order
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            STK_REQ <= '0;
        end else begin
            STK_REQ <= '0;
            if (state == irq_vector_sequencer_pkg::ST_ENTRY && step == 4'h0) begin
                STK_REQ.we <= 1'b1;
                STK_REQ.addr <= sp;
                STK_REQ.wdata <= ret_pc[7:0];
            end else if (state == irq_vector_sequencer_pkg::ST_ENTRY && step == 4'h1) begin
                STK_REQ.we <= 1'b1;
                STK_REQ.addr <= sp - 16'h0001;
                STK_REQ.wdata <= ret_pc[15:8];
            end else if (state == irq_vector_sequencer_pkg::ST_RETURN && step == 4'h0) begin
                STK_REQ.re <= 1'b1;
                STK_REQ.addr <= sp + 16'h0001;
            end else if (state == irq_vector_sequencer_pkg::ST_RETURN && step == 4'h1) begin
                STK_REQ.re <= 1'b1;
                STK_REQ.addr <= sp + `SP_STEP;
            end
        end
    end

    // High byte returns first; keep it for the final load
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pop_hi <= 8'h00;
        end else if (state == irq_vector_sequencer_pkg::ST_RETURN && step == 4'h2) begin
            pop_hi <= STK_RDATA;
        end
    end

    // Program counter loads: vector, then jump target, then return
    // address. The status register is never touched here.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PC_LOAD <= '0;
        end else begin
            PC_LOAD <= '0;
            if (entry_last) begin
                PC_LOAD.load <= 1'b1;
                PC_LOAD.value <= vec;
            end else if (state == irq_vector_sequencer_pkg::ST_JUMP && step == `JUMP_CYCLES - 4'h1) begin
                PC_LOAD.load <= 1'b1;
                PC_LOAD.value <= JUMP_TARGET;
            end else if (ret_last) begin
                PC_LOAD.load <= 1'b1;
                PC_LOAD.value <= {pop_hi, STK_RDATA};
            end
        end
    end

    // Core stalls through every sequence
    assign CORE_HOLD = (state != irq_vector_sequencer_pkg::ST_IDLE);
    assign GLOBAL_EN = gie;

endmodule

// ---- src/irq_vector_sequencer_consts.svh ----
// Register map, field positions and cycle counts of the interrupt sequencer
`ifndef IRQ_VECTOR_SEQUENCER_CONSTS_SVH
`define IRQ_VECTOR_SEQUENCER_CONSTS_SVH

// Register byte offsets on the Wishbone slave
`define REG_CTRL 8'h00
`define REG_ENABLE 8'h04
`define REG_FLAGS 8'h08
`define REG_SP 8'h0C
`define REG_STATUS 8'h10

// Field positions
`define CTRL_GIE_BIT 0
`define STATUS_BUSY_BIT 0
`define STATUS_VEC_LSB 8

// Reset values
`define CTRL_RESET 1'b0
`define ENABLE_RESET 8'h00

// Cycle counts of the sequences
`define ENTRY_CYCLES 4'h4
`define SLEEP_EXTRA_CYCLES 4'h4
`define JUMP_CYCLES 4'h3
`define RETURN_CYCLES 4'h4

// Stack moves two bytes per return address
`define SP_STEP 16'h0002

`endif

// ---- src/irq_vector_sequencer_pkg.sv ----
// Types shared by the interrupt sequencer and its bench
package irq_vector_sequencer_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ENTRY,
        ST_JUMP,
        ST_RETURN
    } seq_state_t;

    // One stack memory access, driven from flops
    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } stk_req_t;

    // Program counter load toward the instruction sequencer
    typedef struct packed {
        logic load;
        logic [15:0] value;
    } pc_load_t;

endpackage

// ---- tb/irq_vector_sequencer_chk.sv ----
// Timing checker for the interrupt sequencer, bound to its top ports
`timescale 1ns/10ps

module irq_vector_sequencer_chk (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Core status
    input wire logic INSTR_DONE,
    input wire logic INSTR_CLI,
    input wire logic INSTR_RETURN_FROM_IRQ_INSTR,
    input wire logic SLEEPING,
    // Sequencer outputs
    input wire logic CORE_HOLD,
    input wire logic GLOBAL_EN,
    input wire irq_vector_sequencer_pkg::pc_load_t PC_LOAD,
    input wire irq_vector_sequencer_pkg::stk_req_t STK_REQ
);
    // One domain, so clock and reset are named once
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // Hold rising without a return behind it marks an entry
    sequence s_entry;
        $rose(CORE_HOLD) && !$past(INSTR_RETURN_FROM_IRQ_INSTR);
    endsequence

    property p_gate;
        INSTR_DONE && !GLOBAL_EN && !INSTR_RETURN_FROM_IRQ_INSTR && !CORE_HOLD |=> !CORE_HOLD;
    endproperty
    property p_cli;
        INSTR_DONE && INSTR_CLI && !INSTR_RETURN_FROM_IRQ_INSTR && !CORE_HOLD |=> !CORE_HOLD;
    endproperty
    property p_clear;
        s_entry |-> !GLOBAL_EN;
    endproperty
    property p_entry;
        s_entry ##0 !$past(SLEEPING) |-> ##4 PC_LOAD.load ##3 (PC_LOAD.load && !CORE_HOLD);
    endproperty
    property p_sleep;
        s_entry ##0 $past(SLEEPING) |-> ##10 CORE_HOLD ##1 !CORE_HOLD;
    endproperty
    property p_ret;
        INSTR_DONE && INSTR_RETURN_FROM_IRQ_INSTR && !CORE_HOLD |=> CORE_HOLD[*4] ##1 (!CORE_HOLD && GLOBAL_EN && PC_LOAD.load);
    endproperty
    // Stack grows downward, so the second push sits one byte lower
    property p_push;
        $rose(STK_REQ.we) |=> STK_REQ.we && STK_REQ.addr == $past(STK_REQ.addr) - 16'h0001;
    endproperty
    property p_pop;
        $rose(STK_REQ.re) |=> STK_REQ.re && STK_REQ.addr == $past(STK_REQ.addr) + 16'h0001;
    endproperty
    property p_boundary;
        $rose(CORE_HOLD) |-> $past(INSTR_DONE);
    endproperty

    a_gate: assert property (p_gate) else $error("entry taken while masked");
    a_cli: assert property (p_cli) else $error("entry taken at disable");
    a_clear: assert property (p_clear) else $error("global enable kept on entry");
    a_entry: assert property (p_entry) else $error("entry timing wrong");
    a_sleep: assert property (p_sleep) else $error("wake entry timing wrong");
    a_ret: assert property (p_ret) else $error("return timing wrong");
    a_push: assert property (p_push) else $error("push address wrong");
    a_pop: assert property (p_pop) else $error("pop address wrong");
    a_boundary: assert property (p_boundary) else $error("sequence off boundary");

    // Main scenarios reached
    c_entry: cover property (s_entry ##0 !$past(SLEEPING));
    c_sleep: cover property (s_entry ##0 $past(SLEEPING));
    c_ret: cover property (INSTR_DONE && INSTR_RETURN_FROM_IRQ_INSTR && !CORE_HOLD);
endmodule

bind irq_vector_sequencer irq_vector_sequencer_chk irq_vector_sequencer_chk_inst (.MCLK(MCLK), .RST(RST),
    .INSTR_DONE(INSTR_DONE), .INSTR_CLI(INSTR_CLI), .INSTR_RETURN_FROM_IRQ_INSTR(INSTR_RETURN_FROM_IRQ_INSTR), .SLEEPING(SLEEPING),
    .CORE_HOLD(CORE_HOLD), .GLOBAL_EN(GLOBAL_EN), .PC_LOAD(PC_LOAD), .STK_REQ(STK_REQ));

// ---- tb/irq_stack_mem.sv ----
// Stack memory model answering the sequencer one cycle after a read
`timescale 1ns/10ps

module irq_stack_mem (
    // Clock
    input wire logic clk,
    // Stack port
    input wire irq_vector_sequencer_pkg::stk_req_t req,
    output logic [7:0] rdata
);
    // Low byte of the address is enough for this stack
    logic [7:0] mem [0:255];

    // Data only holds for the cycle after a read; it toggles otherwise
    always_ff @(posedge clk) begin
        if (req.we)
            mem[req.addr[7:0]] <= req.wdata;
        rdata <= req.re ? mem[req.addr[7:0]] : ~rdata;
    end
endmodule

// ---- tb/irq_vector_sequencer_tb_top.sv ----
// Bench of the interrupt sequencer; core and sources driven here
`timescale 1ns/10ps
`include "irq_vector_sequencer_consts.svh"

module irq_vector_sequencer_tb_top;
    // Clock, reset and Wishbone
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic WB_CYC = 1'b0, WB_STB = 1'b0, WB_WE = 1'b0, WB_ACK;
    logic [7:0] WB_ADR = 8'h00;
    logic [3:0] WB_SEL = 4'hF;
    logic [31:0] WB_DAT_I = 32'h0000_0000, WB_DAT_O;
    // Sources and core status
    logic [7:0] IRQ_EVENT = 8'h00, IRQ_LEVEL = 8'h00, STK_RDATA;
    logic INSTR_DONE = 1'b0, INSTR_SEI = 1'b0, INSTR_CLI = 1'b0, INSTR_RETURN_FROM_IRQ_INSTR = 1'b0, SLEEPING = 1'b0;
    logic [15:0] PC_RETURN = 16'h0000, JUMP_TARGET = 16'h0000;
    logic CORE_HOLD, GLOBAL_EN;
    irq_vector_sequencer_pkg::pc_load_t PC_LOAD;
    irq_vector_sequencer_pkg::stk_req_t STK_REQ;
    // Expected results and return addresses
    logic [31:0] expq[$];
    logic [15:0] rets[$];
    int n_mismatch = 0, total_checks = 0, a, b;

    always #2.5 MCLK = ~MCLK;

    // Source 7 is level type, the rest latch a flag
    irq_vector_sequencer #(.NSRC(8), .FLAG_TYPE(8'h7F), .SP_RESET(16'h00FF)) irq_vector_sequencer_inst (
        .MCLK(MCLK), .RST(RST), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR),
        .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK),
        .IRQ_EVENT(IRQ_EVENT), .IRQ_LEVEL(IRQ_LEVEL), .INSTR_DONE(INSTR_DONE), .INSTR_SEI(INSTR_SEI),
        .INSTR_CLI(INSTR_CLI), .INSTR_RETURN_FROM_IRQ_INSTR(INSTR_RETURN_FROM_IRQ_INSTR), .SLEEPING(SLEEPING), .PC_RETURN(PC_RETURN),
        .JUMP_TARGET(JUMP_TARGET), .CORE_HOLD(CORE_HOLD), .GLOBAL_EN(GLOBAL_EN), .PC_LOAD(PC_LOAD),
        .STK_REQ(STK_REQ), .STK_RDATA(STK_RDATA));
    irq_stack_mem irq_stack_mem_inst (.clk(MCLK), .req(STK_REQ), .rdata(STK_RDATA));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // A wait that ran out ends the run
    task automatic hang(input int i);
        if (i >= 40) begin
            n_mismatch++;
            $display("unexpected handshake: expected answer seen none");
            report_and_stop;
        end
    endtask

    // Mid-cycle sampling keeps clear of the edge where outputs change
    always @(negedge MCLK) begin
        if (!RST && PC_LOAD.load === 1'b1)
            chk("pc load", {16'h0000, PC_LOAD.value}, expq.size() ? expq.pop_front() : 32'bx);
        if (!RST && WB_ACK === 1'b1 && !WB_WE)
            chk("read data", WB_DAT_O, expq.size() ? expq.pop_front() : 32'bx);
    end

    // Classic cycle, held until the edge that samples ack
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int i;
        @(posedge MCLK);
        WB_CYC <= 1'b1;
        WB_STB <= 1'b1;
        WB_WE <= we;
        WB_SEL <= 4'hF;
        WB_ADR <= adr;
        WB_DAT_I <= d;
        i = 0;
        do begin
            @(negedge MCLK);
            i++;
        end while (WB_ACK !== 1'b1 && i < 40);
        hang(i);
        @(posedge MCLK);
        WB_CYC <= 1'b0;
        WB_STB <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        expq.push_back(exp);
        wb(1'b0, adr, 32'h0000_0000);
    endtask

    task automatic ev(input logic [7:0] m);
        @(posedge MCLK);
        IRQ_EVENT <= m;
        @(posedge MCLK);
        IRQ_EVENT <= 8'h00;
    endtask

    // One instruction boundary; vec is the vector expected, 0 for none
    task automatic bnd(input logic s, c, r, slp, input logic [15:0] vec);
        int i;
        logic [15:0] pc, jt;
        pc = 16'($urandom);
        jt = 16'($urandom);
        @(posedge MCLK);
        {INSTR_DONE, INSTR_SEI, INSTR_CLI, INSTR_RETURN_FROM_IRQ_INSTR, SLEEPING} <= {1'b1, s, c, r, slp};
        PC_RETURN <= pc;
        JUMP_TARGET <= jt;
        if (vec != 16'h0000) begin
            expq.push_back({16'h0000, vec});
            expq.push_back({16'h0000, jt});
            rets.push_back(pc);
        end
        if (r)
            expq.push_back({16'h0000, rets.pop_back()});
        @(posedge MCLK);
        {INSTR_DONE, INSTR_SEI, INSTR_CLI, INSTR_RETURN_FROM_IRQ_INSTR, SLEEPING} <= 5'b00000;
        i = 0;
        #1;
        while (CORE_HOLD !== 1'b0 && i < 40) begin
            @(posedge MCLK);
            #1;
            i++;
        end
        hang(i);
    endtask

    initial begin
        void'($urandom(52338));
        a = $urandom % 6;
        b = a + 1 + $urandom % (6 - a);
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        rd(`REG_CTRL, 32'h0000_0000);
        rd(`REG_ENABLE, 32'h0000_0000);
        rd(`REG_SP, 32'h0000_00FF);
        rd(8'h20, 32'h0000_0000);
        $display("test reset values done");
        ev(8'((1 << a) | (1 << b)));
        rd(`REG_FLAGS, 32'((1 << a) | (1 << b)));
        wb(1'b1, `REG_FLAGS, 32'h0000_0000);
        rd(`REG_FLAGS, 32'((1 << a) | (1 << b)));
        wb(1'b1, `REG_FLAGS, 32'(1 << a));
        rd(`REG_FLAGS, 32'(1 << b));
        ev(8'(1 << a));
        wb(1'b1, `REG_ENABLE, 32'h0000_00FF);
        bnd(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        bnd(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
        bnd(1'b0, 1'b0, 1'b0, 1'b0, 16'(a + 1));
        rd(`REG_SP, 32'h0000_00FD);
        rd(`REG_FLAGS, 32'(1 << b));
        bnd(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
        bnd(1'b0, 1'b0, 1'b0, 1'b0, 16'(b + 1));
        bnd(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
        bnd(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
        rd(`REG_SP, 32'h0000_00FF);
        $display("test priority and nesting done");
        ev(8'(1 << a));
        bnd(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
        rd(`REG_FLAGS, 32'(1 << a));
        bnd(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
        bnd(1'b0, 1'b0, 1'b0, 1'b1, 16'(a + 1));
        bnd(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
        $display("test disable and wake done");
        wb(1'b1, `REG_ENABLE, 32'h0000_007F);
        IRQ_LEVEL <= 8'h80;
        wb(1'b1, `REG_ENABLE, 32'h0000_007F);
        IRQ_LEVEL <= 8'h00;
        wb(1'b1, `REG_ENABLE, 32'h0000_00FF);
        bnd(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        IRQ_LEVEL <= 8'h80;
        ev(8'h01);
        bnd(1'b0, 1'b0, 1'b0, 1'b0, 16'h0001);
        bnd(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
        bnd(1'b0, 1'b0, 1'b0, 1'b0, 16'h0008);
        IRQ_LEVEL <= 8'h00;
        bnd(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
        rd(`REG_STATUS, 32'h0000_0800);
        $display("test level source done");
        report_and_stop;
    end
endmodule
